// ---- uss_core.sv ----
// Serial shift unit core: data register, 4-bit counter, output latch, start detector.
// Assumes the serial clock pin drives clk_link_i and the data pad carries a 50..300 ns
// delay cell ahead of sdi_pin_i; strobes are one system cycle wide.
`timescale 1ns/1ps

// Overview of operation
// RQ1: Start detector flags starts only while a two-wire mode is selected.
// RQ2: Data line is delayed 50 to 300 ns before start detection.
// RQ3: Start detector runs without the system clock, so it can wake the processor.
// RQ4: Counter works alone with overflow; external clock counts both edges.
// RQ5: Timer compare match can clock the counter, forming a 12-bit counter.
// RQ6: Counter preset to F plus external clock gives an edge interrupt.
// RQ7: Software strobes alone can overflow the counter, a software interrupt.
// RQ8: Data register has no buffer; accesses reach the live shift register.
// RQ9: A data write in the same cycle as a shift wins; the shift is dropped.
// RQ10: Shift left on external edge, timer match or software strobe per source select.
// RQ11: With outputs disabled the data and clock inputs still feed the shifter.
// RQ12: Active output pin is driven through the output latch from bit 7.
// RQ13: Latch open first half-cycle on external clock, always open on internal.
// RQ14: While the latch is open a new bit 7 reaches the pin at once.
// RQ15: Input sampling and output change occur on opposite serial clock edges.
// RQ16: A full receiver withholds acknowledge for its last byte.
// RQ17: Shift register is eight bits, readable and writable, both directions.
// RQ18: Overflow flag sets when the counter wraps from 15 to 0.
// RQ19: Two-wire mode holds clock low after a start until the flag is cleared.
// RQ20: The asynchronous start flag is synchronised before anything reads it.
module uss_core (
	// System clock and reset.
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Serial clock pin, used as the link clock and as the clock line level.
	input wire logic clk_link_i,
	// Processor side.
	input wire uss_pkg::uss_cfg_t cfg_i,
	input wire uss_pkg::uss_strobe_t stb_i,
	input wire logic data_wr_i,
	input wire logic [uss_pkg::DATA_W-1:0] data_wdata_i,
	input wire logic cnt_wr_i,
	input wire logic [uss_pkg::CNT_W-1:0] cnt_wdata_i,
	output logic [uss_pkg::DATA_W-1:0] serial_data_register_o,
	output logic [uss_pkg::CNT_W-1:0] cnt_o,
	output logic counter_overflow_flag_o,
	output logic start_condition_flag_o,
	output logic collision_o,
	// Pins.
	input wire logic sdi_pin_i,
	output logic sdi_pin_o,
	output logic sdi_pin_oe_o,
	output logic do_pin_o,
	output logic sck_pin_o,
	output logic sck_pin_oe_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: capture the data pin on each serial clock edge.

	logic rise_tgl_q;
	logic rise_bit_q;
	logic fall_tgl_q;
	logic fall_bit_q;

	// The captured bit stays put until the next edge, long after its toggle is synced.
	always_ff @(posedge clk_link_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rise_tgl_q <= 1'b0;
			rise_bit_q <= 1'b0;
		end else begin
			rise_tgl_q <= ~rise_tgl_q; // see RQ11
			rise_bit_q <= sdi_pin_i;
		end
	end

	always_ff @(negedge clk_link_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fall_tgl_q <= 1'b0;
			fall_bit_q <= 1'b0;
		end else begin
			fall_tgl_q <= ~fall_tgl_q; // see RQ11
			fall_bit_q <= sdi_pin_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Start detector, clocked by the falling data line itself.

	logic two_wire;
	logic start_tgl_q;

	assign two_wire = cfg_i.wire_mode_select[uss_pkg::WM_TWO_BIT];

	// A fall of the delayed data line while the clock line is high is a start.
	always_ff @(negedge sdi_pin_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_tgl_q <= 1'b0;
		end else if (two_wire && clk_link_i) begin // see RQ1 see RQ2 see RQ3
			start_tgl_q <= ~start_tgl_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Crossings into the system domain.

	logic [4:0] sync_in;
	logic [4:0] sync_out;
	logic rise_seen_q;
	logic fall_seen_q;
	logic start_seen_q;
	logic ext_rise;
	logic ext_fall;
	logic start_evt;
	logic scl_lvl;
	logic sda_lvl;

	assign sync_in = {rise_tgl_q, fall_tgl_q, start_tgl_q, clk_link_i, sdi_pin_i};

	uss_sync #(
		.W(5)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.async_i(sync_in),
		.sync_o(sync_out)
	);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rise_seen_q <= 1'b0;
			fall_seen_q <= 1'b0;
			start_seen_q <= 1'b0;
		end else begin
			rise_seen_q <= sync_out[4];
			fall_seen_q <= sync_out[3];
			start_seen_q <= sync_out[2];
		end
	end

	assign ext_rise = sync_out[4] ^ rise_seen_q;
	assign ext_fall = sync_out[3] ^ fall_seen_q;
	assign start_evt = (sync_out[2] ^ start_seen_q) & two_wire; // see RQ20
	assign scl_lvl = sync_out[1];
	assign sda_lvl = sync_out[0];

	////////////////////////////////////////////////////////////////////////////////
	// Clock source selection.

	logic ext_src;
	logic sample_evt;
	logic out_evt;
	logic cnt_evt;
	logic sample_bit;

	assign ext_src = cfg_i.external_clock_source_select;

	always_comb begin
		if (ext_src) begin
			sample_evt = cfg_i.clock_edge_source_select ? ext_fall : ext_rise; // see RQ10
			out_evt = cfg_i.clock_edge_source_select ? ext_rise : ext_fall; // see RQ15
			sample_bit = cfg_i.clock_edge_source_select ? fall_bit_q : rise_bit_q;
			// Both edges count; a toggle strobe with the shift strobe counts too.
			cnt_evt = ext_rise | ext_fall |
				(stb_i.clock_toggle_strobe & stb_i.software_shift_strobe); // see RQ4
		end else begin
			sample_evt = cfg_i.clock_edge_source_select ? stb_i.timer_match :
				stb_i.software_shift_strobe; // see RQ5 see RQ7
			out_evt = 1'b0;
			sample_bit = sda_lvl;
			cnt_evt = sample_evt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shift register, read and written directly with no buffer stage.

	logic [uss_pkg::DATA_W-1:0] shift_q;
	logic [uss_pkg::DATA_W-1:0] shift_d;

	always_comb begin
		if (data_wr_i) begin
			shift_d = data_wdata_i; // see RQ9
		end else if (sample_evt) begin
			shift_d = {shift_q[uss_pkg::MSB-1:0], sample_bit}; // see RQ10
		end else begin
			shift_d = shift_q;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_q <= uss_pkg::DATA_RST;
		end else begin
			shift_q <= shift_d; // see RQ8 see RQ17
		end
	end

	assign serial_data_register_o = shift_q;

	////////////////////////////////////////////////////////////////////////////////
	// Bit counter and overflow flag.

	logic [uss_pkg::CNT_W-1:0] cnt_q;
	logic ovf_q;
	logic wrap;

	assign wrap = cnt_evt && !cnt_wr_i && cnt_q == uss_pkg::CNT_MAX;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= uss_pkg::CNT_RST;
		end else if (cnt_wr_i) begin
			cnt_q <= cnt_wdata_i; // see RQ6
		end else if (cnt_evt) begin
			cnt_q <= cnt_q + uss_pkg::CNT_ONE; // see RQ4
		end
	end

	// A wrap in the clearing cycle still sets the flag.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ovf_q <= 1'b0;
		end else if (wrap) begin
			ovf_q <= 1'b1; // see RQ18 see RQ6
		end else if (stb_i.clr_overflow_flag) begin
			ovf_q <= 1'b0;
		end
	end

	assign cnt_o = cnt_q;
	assign counter_overflow_flag_o = ovf_q;

	////////////////////////////////////////////////////////////////////////////////
	// Start flag and clock line hold.

	logic start_q;
	logic hold_q;
	logic hold_want;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_q <= 1'b0;
		end else if (start_evt) begin
			start_q <= 1'b1; // see RQ20
		end else if (stb_i.clr_start_flag) begin
			start_q <= 1'b0;
		end
	end

	assign hold_want = two_wire && (start_q ||
		(ovf_q && cfg_i.wire_mode_select == uss_pkg::WM_TWO_OVF));

	// The hold grabs the line only once the master has pulled it low.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold_q <= 1'b0;
		end else if (!hold_want) begin
			hold_q <= 1'b0; // see RQ19
		end else if (!scl_lvl) begin
			hold_q <= 1'b1; // see RQ19
		end
	end

	assign start_condition_flag_o = start_q;

	////////////////////////////////////////////////////////////////////////////////
	// Output latch and pins.

	logic open_q;
	logic out_q;
	logic latch_open;
	logic sck_q;
	logic sda_oe_q;
	logic do_q;
	logic sck_pin_q;
	logic sck_oe_q;
	logic oe_next;

	// Opens at the output edge, closes at the external sampling edge.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			open_q <= 1'b1;
		end else if (out_evt) begin
			open_q <= 1'b1; // see RQ15
		end else if (ext_src && sample_evt) begin
			open_q <= 1'b0; // see RQ13
		end
	end

	// On external clock the sampling edge itself closes the latch, so a shifted-in bit 7 waits for the output edge.
	assign latch_open = !ext_src || out_evt || (open_q && !sample_evt); // see RQ13 see RQ15

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_q <= 1'b1;
		end else if (latch_open) begin
			out_q <= shift_d[uss_pkg::MSB]; // see RQ12 see RQ14
		end
	end

	assign oe_next = two_wire && !(latch_open ? shift_d[uss_pkg::MSB] : out_q);

	// A receiver that leaves bit 7 at one lets the acknowledge float high.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sda_oe_q <= 1'b0;
			do_q <= 1'b1;
		end else begin
			sda_oe_q <= oe_next; // see RQ16
			do_q <= latch_open ? shift_d[uss_pkg::MSB] : out_q; // see RQ12
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sck_q <= 1'b0;
		end else if (stb_i.clock_toggle_strobe) begin
			sck_q <= ~sck_q;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sck_pin_q <= 1'b0;
			sck_oe_q <= 1'b0;
		end else begin
			sck_pin_q <= hold_q ? 1'b0 : sck_q;
			sck_oe_q <= hold_q || (cfg_i.wire_mode_select == uss_pkg::WM_THREE && !ext_src);
		end
	end

	assign sdi_pin_o = 1'b0;
	assign sdi_pin_oe_o = sda_oe_q;
	assign do_pin_o = do_q;
	assign sck_pin_o = sck_pin_q;
	assign sck_pin_oe_o = sck_oe_q;

	////////////////////////////////////////////////////////////////////////////////
	// Collision: bit 7 against the settled data line level.

	logic [uss_pkg::SETTLE_W-1:0] settle_q;
	logic coll_q;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			settle_q <= uss_pkg::SETTLE_RST;
		end else if (sda_oe_q != oe_next) begin
			settle_q <= uss_pkg::SETTLE_RST;
		end else if (settle_q != uss_pkg::SETTLE_CYC) begin
			settle_q <= settle_q + uss_pkg::SETTLE_ONE;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			coll_q <= 1'b0;
		end else begin
			coll_q <= two_wire && settle_q == uss_pkg::SETTLE_CYC && shift_q[uss_pkg::MSB] != sda_lvl;
		end
	end

	assign collision_o = coll_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	chk_start_mode: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ1
		$rose(start_q) |-> $past(two_wire))
		else $error("start flag set outside two-wire mode");

	chk_start_sync: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ20
		$rose(start_q) |-> $past(sync_out[2]) != $past(start_seen_q))
		else $error("start flag set without a synced start");

	chk_write_wins: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ9
		data_wr_i |=> serial_data_register_o == $past(data_wdata_i))
		else $error("data write lost to a shift");

	chk_shift_left: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ10
		(sample_evt && !data_wr_i) |=>
		serial_data_register_o == {$past(shift_q[uss_pkg::MSB-1:0]), $past(sample_bit)})
		else $error("shift did not move left by one");

	chk_ovf_wrap: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ18
		wrap |=> counter_overflow_flag_o && cnt_o == uss_pkg::CNT_RST)
		else $error("wrap from 15 did not set the overflow flag");

	chk_edge_irq: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ6
		(ext_src && cnt_q == uss_pkg::CNT_MAX && !cnt_wr_i && (ext_rise || ext_fall))
		|=> counter_overflow_flag_o)
		else $error("pin edge with counter at F did not overflow");

	chk_sw_irq: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ7
		(!ext_src && !cfg_i.clock_edge_source_select && stb_i.software_shift_strobe
		&& !cnt_wr_i && cnt_q == uss_pkg::CNT_MAX) |=> counter_overflow_flag_o)
		else $error("software strobe did not raise overflow");

	chk_latch_open: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ14
		(!ext_src && data_wr_i) |=> do_pin_o == $past(data_wdata_i[uss_pkg::MSB]))
		else $error("new bit 7 did not reach the pin through an open latch");

	chk_latch_closed: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ13
		(ext_src && !out_evt && (!open_q || sample_evt)) |=> $stable(out_q))
		else $error("output changed while the latch was closed");

	chk_hold_rel: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RQ19
		(hold_q && !hold_want && two_wire) |=> !hold_q ##1 !sck_pin_oe_o)
		else $error("clock hold not released after flag clear");

endmodule : uss_core

// ---- uss_pkg.sv ----
// Shared types and constants of the serial shift unit.
// Assumes a 125 MHz system clock; the serial clock pin is a clock of its own.
package uss_pkg;

	// Wire mode field codes.
	localparam logic [1:0] WM_OFF = 2'h0;
	localparam logic [1:0] WM_THREE = 2'h1;
	localparam logic [1:0] WM_TWO = 2'h2;
	localparam logic [1:0] WM_TWO_OVF = 2'h3;
	localparam int WM_TWO_BIT = 1;

	// Shift register and counter layout.
	localparam int DATA_W = 8;
	localparam int MSB = 7;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_MAX = 4'hF;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

	// Data line settle time against the system clock.
	localparam int CLK_PERIOD_NS = 8;
	localparam int SDA_DLY_MIN_NS = 50;
	localparam int SDA_DLY_MAX_NS = 300;
	localparam int SDA_DLY_MIN_CYC = (SDA_DLY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 6;
	localparam logic [SETTLE_W-1:0] SETTLE_CYC = SETTLE_W'(SDA_DLY_MIN_CYC);
	localparam logic [SETTLE_W-1:0] SETTLE_RST = 6'h00;
	localparam logic [SETTLE_W-1:0] SETTLE_ONE = 6'h01;

	// Static configuration.
	typedef struct packed {
		logic [1:0] wire_mode_select;
		logic external_clock_source_select;
		logic clock_edge_source_select;
	} uss_cfg_t;

	// One-cycle strobes from the processor and the timer.
	typedef struct packed {
		logic software_shift_strobe;
		logic clock_toggle_strobe;
		logic timer_match;
		logic clr_start_flag;
		logic clr_overflow_flag;
	} uss_strobe_t;

endpackage : uss_pkg

// ---- uss_sync.sv ----
// Two flip-flop level synchroniser into the system clock domain.
// Assumes the input is a level that stays put for several destination cycles.
`timescale 1ns/1ps
module uss_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Data.
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule : uss_sync

// ---- uss_partner_model.sv ----
// Far serial device: drives the clock line and pulls the data line low, open-drain style.
// Assumes the bench resolves both lines with pull-ups and feeds them to the core.
`timescale 1ns/1ps
module uss_partner_model (
	// Line drives of the far device.
	output logic scl_o,
	output logic sda_low_o
);
	localparam realtime HALF = 62.5;

	// The clock stands still high outside frames and the data line is released.
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sends a byte MSB first; data moves while the clock is low, so the rise samples it.
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			scl_o = 1'b0;
			#(HALF / 2.0);
			sda_low_o = ~b[i];
			#(HALF / 2.0);
			scl_o = 1'b1;
			#(HALF);
		end
		sda_low_o = 1'b0;
	endtask : send_byte

	// One lone clock edge.
	task automatic toggle_clk();
		scl_o = ~scl_o;
		#(HALF);
	endtask : toggle_clk

	// Data falls while the clock is high, then the clock is pulled low.
	task automatic start_cond();
		sda_low_o = 1'b1;
		#(HALF);
		scl_o = 1'b0;
		#(HALF);
	endtask : start_cond

	// Releases data while the clock is low, then the clock.
	task automatic release_bus();
		sda_low_o = 1'b0;
		#(HALF);
		scl_o = 1'b1;
		#(HALF);
	endtask : release_bus
endmodule : uss_partner_model

// ---- uss_tb.sv ----
// Self-checking bench for the serial shift unit core.
// Assumes the partner model in its own file; both lines are resolved here with pull-ups.
`timescale 1ns/1ps
module testbench;
	localparam logic [4:0] S_SW = 5'h10;
	localparam logic [4:0] S_TG = 5'h08;
	localparam logic [4:0] S_TM = 5'h04;
	localparam logic [4:0] S_CS = 5'h02;
	localparam logic [4:0] S_CO = 5'h01;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b1;
	uss_pkg::uss_cfg_t cfg = '0;
	uss_pkg::uss_strobe_t stb = '0;
	logic data_wr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic cnt_wr = 1'b0;
	logic [3:0] cwdata = 4'h0;
	logic [7:0] sreg;
	logic [3:0] cnt;
	logic ovf, sflag, sdi_o, sdi_oe, do_pin, sck_pin, sck_oe, p_scl, p_sda_low, coll;
	wire sda_line = ~p_sda_low & ~(sdi_oe & ~sdi_o);
	wire scl_line = p_scl & ~(sck_oe & ~sck_pin);
	int error_cnt = 0;
	int num_checks = 0;

	always #4 clk_sys_i = ~clk_sys_i;

	uss_core u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_link_i(scl_line),
		.cfg_i(cfg), .stb_i(stb), .data_wr_i(data_wr), .data_wdata_i(wdata),
		.cnt_wr_i(cnt_wr), .cnt_wdata_i(cwdata), .serial_data_register_o(sreg),
		.cnt_o(cnt), .counter_overflow_flag_o(ovf), .start_condition_flag_o(sflag),
		.collision_o(coll), .sdi_pin_i(sda_line), .sdi_pin_o(sdi_o), .sdi_pin_oe_o(sdi_oe),
		.do_pin_o(do_pin), .sck_pin_o(sck_pin), .sck_pin_oe_o(sck_oe));
	uss_partner_model u_partner (.scl_o(p_scl), .sda_low_o(p_sda_low));

	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk1

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : wait_cyc

	// One processor cycle: optional data write, counter write and strobes together.
	// It returns at the following falling edge, where the outputs have settled.
	task automatic access(input logic dw, input logic [7:0] dv, input logic cw,
		input logic [3:0] cv, input logic [4:0] s);
		@(posedge clk_sys_i);
		data_wr <= dw;
		wdata <= dv;
		cnt_wr <= cw;
		cwdata <= cv;
		stb <= uss_pkg::uss_strobe_t'(s);
		@(posedge clk_sys_i);
		data_wr <= 1'b0;
		cnt_wr <= 1'b0;
		stb <= '0;
		@(negedge clk_sys_i);
	endtask : access

	task automatic set_cfg(input logic [1:0] m, input logic ext, input logic edg);
		@(posedge clk_sys_i);
		cfg <= uss_pkg::uss_cfg_t'({m, ext, edg});
		wait_cyc(2);
	endtask : set_cfg

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100us;
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		// A falling reset at time zero also clears the flops clocked by the link lines.
		rst_n_i <= 1'b0;
		wait_cyc(4);
		rst_n_i <= 1'b1;
		wait_cyc(3);
		chk8(sreg, 8'h00);
		chk8({4'h0, cnt}, 8'h00);
		chk1(ovf, 1'b0);
		// Software strobe shifts left, line level enters bit 0, bit 7 reaches the pin.
		set_cfg(uss_pkg::WM_OFF, 1'b0, 1'b0);
		access(1'b1, 8'hA5, 1'b0, 4'h0, 5'h00);
		chk8(sreg, 8'hA5);
		wait_cyc(1);
		chk1(do_pin, 1'b1);
		access(1'b1, 8'h25, 1'b0, 4'h0, 5'h00);
		wait_cyc(1);
		chk1(do_pin, 1'b0);
		access(1'b1, 8'hA5, 1'b1, 4'h0, 5'h00);
		access(1'b0, 8'h00, 1'b0, 4'h0, S_SW);
		chk8(sreg, 8'h4B);
		chk8({4'h0, cnt}, 8'h01);
		access(1'b1, 8'h3C, 1'b0, 4'h0, S_SW);
		chk8(sreg, 8'h3C);
		// Timer match as clock: sixteen matches wrap the counter once.
		set_cfg(uss_pkg::WM_OFF, 1'b0, 1'b1);
		access(1'b0, 8'h00, 1'b1, 4'h0, S_CO);
		for (int i = 0; i < 16; i++) begin
			access(1'b0, 8'h00, 1'b0, 4'h0, S_TM);
			if (i == 14) chk1(ovf, 1'b0);
		end
		chk8({4'h0, cnt}, 8'h00);
		chk1(ovf, 1'b1);
		// Software interrupt, by shift strobe and by toggle strobe on the external source.
		for (int k = 0; k < 2; k++) begin
			set_cfg(uss_pkg::WM_OFF, k[0], 1'b0);
			access(1'b0, 8'h00, 1'b1, uss_pkg::CNT_MAX, S_CO);
			chk1(ovf, 1'b0);
			access(1'b0, 8'h00, 1'b0, 4'h0, (k == 0) ? S_SW : (S_SW | S_TG));
			chk1(ovf, 1'b1);
		end
		// External clock with outputs off: a byte arrives over sixteen edges.
		set_cfg(uss_pkg::WM_OFF, 1'b1, 1'b0);
		access(1'b1, 8'h00, 1'b1, 4'h0, S_CO);
		u_partner.send_byte(8'h3C);
		wait_cyc(10);
		chk8(sreg, 8'h3C);
		chk8({4'h0, cnt}, 8'h00);
		chk1(ovf, 1'b1);
		// Last edge sampled: the closed latch keeps the old bit 7 (0) against a new one.
		access(1'b1, 8'h80, 1'b0, 4'h0, 5'h00);
		wait_cyc(3);
		chk1(do_pin, 1'b0);
		// Counter at F: the next pin edge is an edge interrupt.
		access(1'b0, 8'h00, 1'b1, uss_pkg::CNT_MAX, S_CO);
		chk1(ovf, 1'b0);
		u_partner.toggle_clk();
		wait_cyc(10);
		chk1(ovf, 1'b1);
		chk1(do_pin, 1'b1);
		u_partner.toggle_clk();
		wait_cyc(10);
		// Start detector: ignored in three-wire, flags and holds the clock in two-wire.
		set_cfg(uss_pkg::WM_THREE, 1'b0, 1'b0);
		access(1'b1, 8'hFF, 1'b0, 4'h0, S_CS | S_CO);
		u_partner.start_cond();
		wait_cyc(10);
		chk1(sflag, 1'b0);
		u_partner.release_bus();
		set_cfg(uss_pkg::WM_TWO, 1'b0, 1'b0);
		u_partner.start_cond();
		wait_cyc(10);
		chk1(sflag, 1'b1);
		chk1(sck_oe & ~sck_pin, 1'b1);
		// Bit 7 at one against the line held low by the partner is a collision.
		chk1(coll, 1'b1);
		access(1'b1, 8'h00, 1'b0, 4'h0, 5'h00);
		wait_cyc(10);
		chk1(sdi_oe, 1'b1);
		chk1(coll, 1'b0);
		access(1'b1, 8'hFF, 1'b0, 4'h0, 5'h00);
		chk1(sdi_oe, 1'b0);
		access(1'b0, 8'h00, 1'b0, 4'h0, S_CS);
		wait_cyc(3);
		chk1(sflag, 1'b0);
		chk1(sck_oe, 1'b0);
		u_partner.release_bus();
		wait_cyc(4);
		// Mode 3: an overflow holds the clock once the master pulls it low.
		set_cfg(uss_pkg::WM_TWO_OVF, 1'b0, 1'b0);
		access(1'b0, 8'h00, 1'b1, uss_pkg::CNT_MAX, S_CO);
		access(1'b0, 8'h00, 1'b0, 4'h0, S_SW);
		chk1(ovf, 1'b1);
		u_partner.toggle_clk();
		wait_cyc(10);
		chk1(sck_oe & ~sck_pin, 1'b1);
		access(1'b0, 8'h00, 1'b0, 4'h0, S_CO);
		wait_cyc(3);
		chk1(sck_oe, 1'b0);
		u_partner.toggle_clk();
		wait_cyc(4);
		tally_and_finish();
	end
endmodule : testbench
